// File: dwr_pkg.sv
`default_nettype none
package dwr_pkg;

  // ---------------------------------------------------------------
  // register map: word index, byte address is index times four
  // ---------------------------------------------------------------
  localparam int         ADDR_W       = 8;
  localparam int         ADDR_LSB     = 2;
  localparam logic [5:0] IDX_CH1_EXT  = 6'h2D;
  localparam logic [5:0] IDX_CH0_MODE = 6'h31;
  localparam logic [5:0] IDX_WAIT     = 6'h32;
  localparam logic [5:0] IDX_CTRL     = 6'h34;
  localparam logic [5:0] IDX_CNT0     = 6'h35;
  localparam logic [5:0] IDX_CNT1     = 6'h36;

  // ---------------------------------------------------------------
  // field layouts
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] memory_wait_count;
    logic [1:0] io_wait_count;
    logic       sense1_edge;
    logic       sense0_edge;
    logic [1:0] chan1_direction_mode;
  } dwr_wait_ctl_t;

  typedef struct packed {
    logic       alt_en;
    logic       alt_sel;
    logic [1:0] rsv;
    logic       pin_timer;
    logic [2:0] src;
  } dwr_ext_t;

  typedef struct packed {
    logic rsv;
    logic done1;
    logic done0;
    logic guard1;
    logic en1;
    logic irq0;
    logic guard0;
    logic en0;
  } dwr_ctrl_t;

  typedef struct packed {
    logic [5:0] rsv_hi;
    logic       burst;
    logic       rsv_lo;
  } dwr_mode_t;

  // direction bit 1: i/o to memory, bit 0: memory address steps down
  localparam int DIR_TO_MEM = 1;
  localparam int DIR_DEC    = 0;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [1:0]    WAIT_RST     = 2'h3;
  localparam dwr_wait_ctl_t WAIT_CTL_RST = '{
    memory_wait_count: WAIT_RST,
    io_wait_count:     WAIT_RST,
    default:           '0
  };
  localparam logic [2:0]  SRC_EXT      = 3'h0;
  localparam logic [2:0]  SRC_SER_A    = 3'h1;
  localparam logic [2:0]  SRC_SER_B    = 3'h2;
  localparam logic [2:0]  SRC_CLK_PIN  = 3'h3;
  localparam logic [15:0] CNT_LAST     = 16'h0001;
  localparam logic [15:0] CNT_STEP     = 16'h0001;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_CPU,
    ST_XFER0,
    ST_XFER1
  } dwr_fsm_t;

  typedef struct packed {
    dwr_wait_ctl_t wctl;
    dwr_ext_t      ext;
    logic          burst;
    logic          en0;
    logic          en1;
    logic          irq0;
    logic          done0;
    logic          done1;
    logic [15:0]   cnt0;
    logic [15:0]   cnt1;
    dwr_fsm_t      fsm;
    logic          ack;
    logic          tmr;
    logic [15:0]   rdata;
  } dwr_core_t;

  typedef struct packed {
    logic prev;
    logic flag;
  } dwr_sense_t;

  function automatic logic [15:0] dwr_merge(input logic [15:0] old,
                                            input logic [15:0] wd,
                                            input logic [1:0]  be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

endpackage
`default_nettype wire

// File: dwr_req_sense.sv
`timescale 1ns/1ns
`default_nettype none
module dwr_req_sense (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic req_i,
  input  wire logic edge_i,
  input  wire logic take_i,
  output logic      pend_o
);

  dwr_pkg::dwr_sense_t q;
  dwr_pkg::dwr_sense_t d;

  // ---------------------------------------------------------------
  // level or edge request
  // ---------------------------------------------------------------
  always_comb begin
    d      = q;
    d.prev = req_i;
    // a new edge in the cycle of a take still counts
    d.flag = (req_i & ~q.prev) | (q.flag & ~take_i);
    if (!edge_i) begin
      d.flag = 1'b0;
    end
  end

  assign pend_o = edge_i ? q.flag : req_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule
`default_nettype wire

// File: dwr_top.sv
// Functional notes
// - Memory wait field sets wait states on every memory cycle.
// - I/O wait field sets wait states on every I/O cycle.
// - Per-channel sense bit: zero level request, one edge request.
// - Channel 1 mode picks direction and memory step; I/O address fixed.
// - Alternation bit: zero independent channels, one channels take turns.
// - Channel 0 terminal count sets selector; shared request goes to channel 1.
// - Channel 1 terminal count clears selector; shared request goes to channel 0.
// - Differing sources: channel 0 request steered to channel 1 once set.
// - Selector bit readable, writable, toggled by terminal counts while alternating.
// - Pin bit: zero shared pin is request input, one timer output.
// - Low three bits with direction choose channel 1 request source.
// - Channel 0 memory transfers ignore external request; paced automatically.
// - Channel 0 keeps transferring without requests until count reaches zero.
// - Burst pacing holds the bus until the whole transfer ends.
// - Cycle steal alternates one CPU cycle with one DMA byte.
// - Enable with guard clear in one write; start one machine cycle later.
// - Pacing bit one selects burst, zero selects cycle steal.
`timescale 1ns/1ns
`default_nettype none
module dwr_top (
  input  wire logic        REF_CLK_I,
  input  wire logic        NRST_I,
  input  wire logic [7:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  input  wire logic        CH0_REQ_N_I,
  input  wire logic        CH0_ACK_I,
  input  wire logic        CH1_REQ_N_I,
  input  wire logic        SER_A_TX_REQ_I,
  input  wire logic        SER_A_RX_REQ_I,
  input  wire logic        SER_B_TX_REQ_I,
  input  wire logic        SER_B_RX_REQ_I,
  input  wire logic        CLK_REQ_PIN_N_I,
  input  wire logic        TIMER_OUT_I,
  input  wire logic        TMR_REQ_PIN_I,
  output logic             TMR_REQ_PIN_O,
  output logic             TMR_REQ_PIN_OE_O,
  input  wire logic        CYCLE_DONE_I,
  output logic [1:0]       MEM_WAIT_O,
  output logic [1:0]       IO_WAIT_O,
  output logic             DMA_OWN_O,
  output logic             DMA_CHAN_O,
  output logic             CH1_TO_MEM_O,
  output logic             CH1_MEM_DEC_O,
  output logic             CH0_REQ_O,
  output logic             TC0_N_O,
  output logic             TC1_N_O,
  output logic             CH0_DONE_IRQ_O
);

  dwr_pkg::dwr_core_t q;
  dwr_pkg::dwr_core_t d;

  logic        bus_req;
  logic        wr_fire;
  logic [5:0]  idx;
  logic [15:0] wdat;
  logic [15:0] rd_val;
  logic        pin_req;
  logic        ch0_raw;
  logic        src1_req;
  logic        ch0_line;
  logic        ch1_line;
  logic        pend0;
  logic        pend1;
  logic        take1;
  logic        last0;
  logic        last1;

  // ---------------------------------------------------------------
  // bus slave: one wait cycle on every access
  // ---------------------------------------------------------------
  assign bus_req = AVS_READ_I | AVS_WRITE_I;
  assign wr_fire = AVS_WRITE_I & q.ack;
  assign idx     = AVS_ADDRESS_I[dwr_pkg::ADDR_W-1:dwr_pkg::ADDR_LSB];
  assign wdat    = AVS_WRITEDATA_I[15:0];

  always_comb begin
    dwr_pkg::dwr_ctrl_t rc;
    dwr_pkg::dwr_mode_t rm;
    rc        = '0;
    rc.done1  = q.done1;
    rc.done0  = q.done0;
    rc.guard1 = 1'b1;
    rc.en1    = q.en1;
    rc.irq0   = q.irq0;
    rc.guard0 = 1'b1;
    rc.en0    = q.en0;
    rm        = '0;
    rm.burst  = q.burst;
    case (idx)
      dwr_pkg::IDX_CH1_EXT: begin
        rd_val = {8'h00, q.ext};
      end
      dwr_pkg::IDX_CH0_MODE: begin
        rd_val = {8'h00, rm};
      end
      dwr_pkg::IDX_WAIT: begin
        rd_val = {8'h00, q.wctl};
      end
      dwr_pkg::IDX_CTRL: begin
        rd_val = {8'h00, rc};
      end
      dwr_pkg::IDX_CNT0: begin
        rd_val = q.cnt0;
      end
      dwr_pkg::IDX_CNT1: begin
        rd_val = q.cnt1;
      end
      default: begin
        rd_val = 16'h0000;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // request routing
  // ---------------------------------------------------------------
  assign pin_req = ~q.ext.pin_timer & ~TMR_REQ_PIN_I;
  assign ch0_raw = ~CH0_REQ_N_I;

  always_comb begin
    case (q.ext.src)
      dwr_pkg::SRC_EXT: begin
        src1_req = q.ext.pin_timer ? ~CH1_REQ_N_I : pin_req;
      end
      dwr_pkg::SRC_SER_A: begin
        src1_req = q.wctl.chan1_direction_mode[dwr_pkg::DIR_TO_MEM] ?
                   SER_A_RX_REQ_I : SER_A_TX_REQ_I;
      end
      dwr_pkg::SRC_SER_B: begin
        src1_req = q.wctl.chan1_direction_mode[dwr_pkg::DIR_TO_MEM] ?
                   SER_B_RX_REQ_I : SER_B_TX_REQ_I;
      end
      dwr_pkg::SRC_CLK_PIN: begin
        src1_req = ~CLK_REQ_PIN_N_I;
      end
      default: begin
        src1_req = 1'b0;
      end
    endcase
  end

  // the selector decides who sees the shared request; with
  // differing sources channel 0's request is the one moved over
  always_comb begin
    if (q.ext.alt_en) begin
      ch0_line = ch0_raw & ~q.ext.alt_sel;
      ch1_line = ch0_raw & q.ext.alt_sel;
    end else begin
      ch0_line = ch0_raw;
      ch1_line = src1_req;
    end
  end

  dwr_req_sense u_sense0 (
    .clk_i   (REF_CLK_I),
    .rst_n_i (NRST_I),
    .req_i   (ch0_line),
    .edge_i  (q.wctl.sense0_edge),
    .take_i  (CH0_ACK_I),
    .pend_o  (pend0)
  );

  dwr_req_sense u_sense1 (
    .clk_i   (REF_CLK_I),
    .rst_n_i (NRST_I),
    .req_i   (ch1_line),
    .edge_i  (q.wctl.sense1_edge),
    .take_i  (take1),
    .pend_o  (pend1)
  );

  // ---------------------------------------------------------------
  // registers and transfer sequencer
  // ---------------------------------------------------------------
  assign last0 = (q.cnt0 == dwr_pkg::CNT_LAST);
  assign last1 = (q.cnt1 == dwr_pkg::CNT_LAST);
  assign take1 = (q.fsm == dwr_pkg::ST_XFER1) & CYCLE_DONE_I;

  always_comb begin
    dwr_pkg::dwr_ctrl_t wc;
    dwr_pkg::dwr_ext_t  we;
    dwr_pkg::dwr_mode_t wm;
    wc      = dwr_pkg::dwr_ctrl_t'(wdat[7:0]);
    we      = dwr_pkg::dwr_ext_t'(wdat[7:0]);
    wm      = dwr_pkg::dwr_mode_t'(wdat[7:0]);
    d       = q;
    d.tmr   = TIMER_OUT_I;
    d.ack   = bus_req & ~q.ack;
    if (AVS_READ_I && !q.ack) begin
      d.rdata = rd_val;
    end

    // software writes first, so that hardware events below win
    if (wr_fire) begin
      case (idx)
        dwr_pkg::IDX_CH1_EXT: begin
          if (AVS_BYTEENABLE_I[0]) begin
            d.ext     = we;
            d.ext.rsv = '0;
          end
        end
        dwr_pkg::IDX_CH0_MODE: begin
          if (AVS_BYTEENABLE_I[0]) begin
            d.burst = wm.burst;
          end
        end
        dwr_pkg::IDX_WAIT: begin
          if (AVS_BYTEENABLE_I[0]) begin
            d.wctl = dwr_pkg::dwr_wait_ctl_t'(wdat[7:0]);
          end
        end
        dwr_pkg::IDX_CTRL: begin
          if (AVS_BYTEENABLE_I[0]) begin
            d.irq0 = wc.irq0;
            if (!wc.guard0) begin
              d.en0 = wc.en0;
              if (wc.en0) begin
                d.done0 = 1'b0;
              end
            end
            if (!wc.guard1) begin
              d.en1 = wc.en1;
              if (wc.en1) begin
                d.done1 = 1'b0;
              end
            end
          end
        end
        dwr_pkg::IDX_CNT0: begin
          d.cnt0 = dwr_pkg::dwr_merge(q.cnt0, wdat, AVS_BYTEENABLE_I[1:0]);
        end
        dwr_pkg::IDX_CNT1: begin
          d.cnt1 = dwr_pkg::dwr_merge(q.cnt1, wdat, AVS_BYTEENABLE_I[1:0]);
        end
        default: begin
        end
      endcase
    end

    case (q.fsm)
      dwr_pkg::ST_IDLE: begin
        if (q.en0) begin
          d.fsm = dwr_pkg::ST_START;
        end else if (CYCLE_DONE_I && q.en1 && pend1) begin
          d.fsm = dwr_pkg::ST_XFER1;
        end
      end
      dwr_pkg::ST_START: begin
        // the machine cycle running at enable time is left to the cpu
        if (!q.en0) begin
          d.fsm = dwr_pkg::ST_IDLE;
        end else if (CYCLE_DONE_I) begin
          d.fsm = dwr_pkg::ST_XFER0;
        end
      end
      dwr_pkg::ST_CPU: begin
        if (!q.en0) begin
          d.fsm = dwr_pkg::ST_IDLE;
        end else if (CYCLE_DONE_I) begin
          d.fsm = dwr_pkg::ST_XFER0;
        end
      end
      dwr_pkg::ST_XFER0: begin
        if (CYCLE_DONE_I) begin
          d.cnt0 = q.cnt0 - dwr_pkg::CNT_STEP;
          if (last0) begin
            d.en0   = 1'b0;
            d.done0 = 1'b1;
            d.fsm   = dwr_pkg::ST_IDLE;
            if (q.ext.alt_en) begin
              d.ext.alt_sel = 1'b1;
            end
          end else if (!q.en0) begin
            d.fsm = dwr_pkg::ST_IDLE;
          end else if (q.burst) begin
            d.fsm = dwr_pkg::ST_XFER0;
          end else begin
            d.fsm = dwr_pkg::ST_CPU;
          end
        end
      end
      dwr_pkg::ST_XFER1: begin
        if (CYCLE_DONE_I) begin
          d.cnt1 = q.cnt1 - dwr_pkg::CNT_STEP;
          d.fsm  = dwr_pkg::ST_IDLE;
          if (last1) begin
            d.en1   = 1'b0;
            d.done1 = 1'b1;
            if (q.ext.alt_en) begin
              d.ext.alt_sel = 1'b0;
            end
          end
        end
      end
      default: begin
        d.fsm = dwr_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      q      <= '0;
      q.wctl <= dwr_pkg::WAIT_CTL_RST;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign AVS_READDATA_O    = {16'h0000, q.rdata};
  assign AVS_WAITREQUEST_O = bus_req & ~q.ack;
  assign MEM_WAIT_O        = q.wctl.memory_wait_count;
  assign IO_WAIT_O         = q.wctl.io_wait_count;
  assign DMA_OWN_O         = (q.fsm == dwr_pkg::ST_XFER0) |
                             (q.fsm == dwr_pkg::ST_XFER1);
  assign DMA_CHAN_O        = (q.fsm == dwr_pkg::ST_XFER1);
  assign CH1_TO_MEM_O      = q.wctl.chan1_direction_mode[dwr_pkg::DIR_TO_MEM];
  assign CH1_MEM_DEC_O     = q.wctl.chan1_direction_mode[dwr_pkg::DIR_DEC];
  assign CH0_REQ_O         = pend0;
  assign TC0_N_O           = ~((q.fsm == dwr_pkg::ST_XFER0) & last0);
  assign TC1_N_O           = ~((q.fsm == dwr_pkg::ST_XFER1) & last1);
  assign CH0_DONE_IRQ_O    = q.done0 & q.irq0;
  // pin copy lags the timer by one clock so the pad is driven from a flop
  assign TMR_REQ_PIN_O     = q.tmr;
  assign TMR_REQ_PIN_OE_O  = q.ext.pin_timer;

endmodule
`default_nettype wire

// File: dwr_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module dwr_bus_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [1:0] wait_i,
  output logic            done_o
);
  logic [2:0] cnt_q;
  // ----
  // machine cycle: three clocks plus the memory waits
  // ----
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 3'h0;
      done_o <= 1'b0;
    end else begin
      done_o <= (cnt_q == 3'h0);
      cnt_q  <= (cnt_q == 3'h0) ? {1'b0, wait_i} + 3'h2 : cnt_q - 3'h1;
    end
  end
endmodule
`default_nettype wire

// File: dwr_checker.sv
`timescale 1ns/1ns
`default_nettype none
module dwr_checker (
  input wire logic        REF_CLK_I,
  input wire logic        NRST_I,
  input wire logic [7:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [3:0]  AVS_BYTEENABLE_I,
  input wire logic        AVS_WAITREQUEST_O,
  input wire logic        TIMER_OUT_I,
  input wire logic        TMR_REQ_PIN_O,
  input wire logic        TMR_REQ_PIN_OE_O,
  input wire logic        CYCLE_DONE_I,
  input wire logic [1:0]  MEM_WAIT_O,
  input wire logic [1:0]  IO_WAIT_O,
  input wire logic        DMA_OWN_O,
  input wire logic        DMA_CHAN_O,
  input wire logic        CH1_TO_MEM_O,
  input wire logic        CH1_MEM_DEC_O,
  input wire logic        TC0_N_O,
  input wire logic        TC1_N_O
);
  logic burst_q;
  logic wr_ok;
  assign wr_ok = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_BYTEENABLE_I[0];
  // pacing bit is no port, so it is shadowed from bus writes
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      burst_q <= 1'b0;
    end else if (wr_ok && AVS_ADDRESS_I[7:2] == dwr_pkg::IDX_CH0_MODE) begin
      burst_q <= AVS_WRITEDATA_I[1];
    end
  end
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);
  sequence s_wr(logic [5:0] idx);
    wr_ok && AVS_ADDRESS_I[7:2] == idx;
  endsequence
  sequence s_byte0(logic b);
    DMA_OWN_O && !DMA_CHAN_O && CYCLE_DONE_I && TC0_N_O && burst_q == b;
  endsequence
  chk_one_wait:
    assert property ($rose(AVS_READ_I || AVS_WRITE_I) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
      else $error("bus answer not after one wait");
  chk_wait_fields:
    assert property (s_wr(dwr_pkg::IDX_WAIT) |=> MEM_WAIT_O == $past(AVS_WRITEDATA_I[7:6])
      && IO_WAIT_O == $past(AVS_WRITEDATA_I[5:4])) else $error("wait fields not loaded");
  chk_dir_bits:
    assert property (s_wr(dwr_pkg::IDX_WAIT) |=> CH1_TO_MEM_O == $past(AVS_WRITEDATA_I[1])
      && CH1_MEM_DEC_O == $past(AVS_WRITEDATA_I[0])) else $error("direction bits wrong");
  chk_pin_timer:
    assert property (TMR_REQ_PIN_OE_O |-> TMR_REQ_PIN_O == $past(TIMER_OUT_I))
      else $error("timer pin not following");
  chk_tc0_chan:
    assert property (!TC0_N_O |-> DMA_OWN_O && !DMA_CHAN_O) else $error("tc0 outside ch0 byte");
  chk_tc1_chan:
    assert property (!TC1_N_O |-> DMA_OWN_O && DMA_CHAN_O) else $error("tc1 outside ch1 byte");
  chk_steal_gap:
    assert property (s_byte0(1'b0) |=> !DMA_OWN_O [*3]) else $error("no cpu cycle between");
  chk_burst_hold:
    assert property (s_byte0(1'b1) |=> DMA_OWN_O && !DMA_CHAN_O) else $error("burst let go");
  chk_tc0_stop:
    assert property (!TC0_N_O && CYCLE_DONE_I |=> !DMA_OWN_O ##1 !DMA_OWN_O)
      else $error("ch0 kept bus after last");
  chk_start_soon:
    assert property (s_wr(dwr_pkg::IDX_CTRL) ##0 (AVS_WRITEDATA_I[1:0] == 2'h1)
      |=> !DMA_OWN_O ##[1:40] (DMA_OWN_O && !DMA_CHAN_O)) else $error("ch0 start wrong");
endmodule
bind dwr_top dwr_checker i_dwr_checker (.*);
`default_nettype wire

// File: dma_wait_request_control_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dma_wait_request_control_tb;
  logic [31:0] AVS_WRITEDATA_I, AVS_READDATA_O, seed, r;
  logic [15:0] rv;
  logic [7:0]  AVS_ADDRESS_I, d;
  logic [3:0]  AVS_BYTEENABLE_I;
  logic [1:0]  MEM_WAIT_O, IO_WAIT_O;
  logic        REF_CLK_I, NRST_I, AVS_READ_I, AVS_WRITE_I, AVS_WAITREQUEST_O, pin_drv;
  logic        CH0_REQ_N_I, CH0_ACK_I, CH1_REQ_N_I, CLK_REQ_PIN_N_I, TIMER_OUT_I;
  logic        SER_A_TX_REQ_I, SER_A_RX_REQ_I, SER_B_TX_REQ_I, SER_B_RX_REQ_I;
  logic        TMR_REQ_PIN_O, TMR_REQ_PIN_OE_O, CYCLE_DONE_I, CH0_REQ_O;
  logic        DMA_OWN_O, DMA_CHAN_O, CH1_TO_MEM_O, CH1_MEM_DEC_O;
  logic        TC0_N_O, TC1_N_O, CH0_DONE_IRQ_O;
  int          miscompares, tests_run, nb0, nb1, ntc0, ntc1;
  wire logic   TMR_REQ_PIN_I = TMR_REQ_PIN_OE_O ? TMR_REQ_PIN_O : pin_drv;
  dwr_top i_dwr_top (.*);
  dwr_bus_model i_dwr_bus_model (.clk_i(REF_CLK_I), .rst_n_i(NRST_I), .wait_i(MEM_WAIT_O),
                                 .done_o(CYCLE_DONE_I));
  initial begin
    REF_CLK_I = 1'b0;
    forever #10 REF_CLK_I = ~REF_CLK_I;
  end
  always @(posedge REF_CLK_I) TIMER_OUT_I <= ~TIMER_OUT_I;
  always @(negedge REF_CLK_I) begin
    if (CYCLE_DONE_I && DMA_OWN_O) begin
      if (DMA_CHAN_O) nb1++;
      else nb0++;
    end
    if (CYCLE_DONE_I && !TC0_N_O) ntc0++;
    if (CYCLE_DONE_I && !TC1_N_O) ntc1++;
  end
  // ----
  // helpers
  // ----
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ticks(input int k);
    repeat (k) @(negedge REF_CLK_I);
  endtask
  // request held until waitrequest is seen low before the edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] wd);
    @(posedge REF_CLK_I);
    AVS_ADDRESS_I   <= {a, 2'h0};
    AVS_WRITEDATA_I <= {16'h0000, wd};
    AVS_WRITE_I     <= w;
    AVS_READ_I      <= !w;
    @(negedge REF_CLK_I);
    while (AVS_WAITREQUEST_O !== 1'b0) begin
      @(negedge REF_CLK_I);
    end
    // data is taken at the very edge that sees waitrequest low
    @(posedge REF_CLK_I);
    rv = AVS_READDATA_O[15:0];
    AVS_WRITE_I <= 1'b0;
    AVS_READ_I  <= 1'b0;
  endtask
  // reserved codes get every line active at once
  task automatic route(input int c, input logic dir, input logic on);
    logic all;
    all = on && c > 3 && c < 8;
    pin_drv         <= !(on && c == 0 || all);
    SER_A_TX_REQ_I  <= on && c == 1 && !dir || all;
    SER_A_RX_REQ_I  <= on && c == 1 && dir || all;
    SER_B_TX_REQ_I  <= on && c == 2 && !dir || all;
    SER_B_RX_REQ_I  <= on && c == 2 && dir || all;
    CLK_REQ_PIN_N_I <= !(on && c == 3 || all);
    CH1_REQ_N_I     <= !(on && c == 8 || all);
  endtask
  task automatic xfer0(input logic b, input logic [15:0] n);
    r = xs();
    bus(1'b1, dwr_pkg::IDX_WAIT, {8'h00, r[7:4], 4'h0});
    bus(1'b1, dwr_pkg::IDX_CNT0, n);
    bus(1'b1, dwr_pkg::IDX_CH0_MODE, {14'h0, b, 1'b0});
    nb0 = 0;
    ntc0 = 0;
    bus(1'b1, dwr_pkg::IDX_CTRL, 16'h0005);
    while (ntc0 == 0 || DMA_OWN_O !== 1'b0) begin
      @(negedge REF_CLK_I);
    end
    chk("ch0 bytes", n, 16'(nb0));
    chk("ch0 last", 16'h1, 16'(ntc0));
    chk("ch0 irq", 16'h1, {15'h0, CH0_DONE_IRQ_O});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge REF_CLK_I);
    miscompares++;
    results();
  end
  // ----
  // tests
  // ----
  initial begin
    seed = 32'h9;
    NRST_I = 1'b0;
    {AVS_ADDRESS_I, AVS_WRITEDATA_I, AVS_READ_I, AVS_WRITE_I} = '0;
    AVS_BYTEENABLE_I = 4'h3;
    {CH0_REQ_N_I, CH0_ACK_I, TIMER_OUT_I} = 3'h4;
    route(0, 1'b0, 1'b0);
    repeat (3) @(posedge REF_CLK_I);
    NRST_I <= 1'b1;
    ticks(1);
    chk("mem wait", 16'h3, {14'h0, MEM_WAIT_O});
    chk("io wait", 16'h3, {14'h0, IO_WAIT_O});
    bus(1'b0, dwr_pkg::IDX_WAIT, 16'h0);
    chk("wait reg", 16'h00F0, rv);
    bus(1'b0, dwr_pkg::IDX_CH1_EXT, 16'h0);
    chk("ext reg", 16'h0, rv);
    bus(1'b0, 6'h00, 16'h0);
    chk("unmapped", 16'h0, rv);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      r = xs();
      d = {r[7:2], i[1:0]};
      bus(1'b1, dwr_pkg::IDX_WAIT, {8'h0, d});
      bus(1'b0, dwr_pkg::IDX_WAIT, 16'h0);
      chk("wait rd", {8'h0, d}, rv);
      chk("to mem", {15'h0, d[1]}, {15'h0, CH1_TO_MEM_O});
      chk("mem dec", {15'h0, d[0]}, {15'h0, CH1_MEM_DEC_O});
      bus(1'b1, dwr_pkg::IDX_CH1_EXT, {8'h0, r[15:8] | 8'h30});
      bus(1'b0, dwr_pkg::IDX_CH1_EXT, 16'h0);
      chk("ext rd", {8'h0, r[15:8] & 8'hCF}, rv);
    end
    $display("test registers done");
    bus(1'b1, dwr_pkg::IDX_CH1_EXT, 16'h0);
    bus(1'b1, dwr_pkg::IDX_WAIT, 16'h0004);
    CH0_REQ_N_I <= 1'b0;
    ticks(3);
    chk("edge pend", 16'h1, {15'h0, CH0_REQ_O});
    @(posedge REF_CLK_I) CH0_ACK_I <= 1'b1;
    @(posedge REF_CLK_I) CH0_ACK_I <= 1'b0;
    ticks(2);
    chk("edge taken", 16'h0, {15'h0, CH0_REQ_O});
    bus(1'b1, dwr_pkg::IDX_WAIT, 16'h0);
    ticks(2);
    chk("level pend", 16'h1, {15'h0, CH0_REQ_O});
    @(posedge REF_CLK_I);
    CH0_REQ_N_I <= 1'b1;
    bus(1'b1, dwr_pkg::IDX_CNT0, 16'h0003);
    nb0 = 0;
    bus(1'b1, dwr_pkg::IDX_CTRL, 16'h0003);
    ticks(40);
    chk("guarded", 16'h0, 16'(nb0));
    bus(1'b0, dwr_pkg::IDX_CTRL, 16'h0);
    chk("en0 bit", 16'h0, {15'h0, rv[0]});
    $display("test sense done");
    for (int m = 0; m < 2; m++) begin
      r = xs();
      xfer0(m[0], {14'h0, r[1:0]} + 16'h2);
    end
    $display("test ch0 done");
    for (int c = 0; c < 9; c++) begin
      r = xs();
      bus(1'b1, dwr_pkg::IDX_WAIT, {14'h0, r[0], 1'b0});
      bus(1'b1, dwr_pkg::IDX_CH1_EXT, (c == 8) ? 16'h0008 : 16'(c));
      bus(1'b1, dwr_pkg::IDX_CNT1, 16'h0001);
      ticks(1);
      chk("pin oe", {15'h0, c == 8}, {15'h0, TMR_REQ_PIN_OE_O});
      nb1 = 0;
      ntc1 = 0;
      bus(1'b1, dwr_pkg::IDX_CTRL, 16'h0008);
      route(c, r[0], 1'b1);
      ticks(30);
      @(posedge REF_CLK_I);
      route(c, r[0], 1'b0);
      chk("ch1 served", {15'h0, c < 4 || c == 8}, 16'(nb1));
      chk("ch1 last", {15'h0, c < 4 || c == 8}, 16'(ntc1));
    end
    $display("test ch1 done");
    bus(1'b1, dwr_pkg::IDX_WAIT, 16'h0);
    bus(1'b1, dwr_pkg::IDX_CH1_EXT, 16'h0080);
    CH0_REQ_N_I <= 1'b0;
    bus(1'b1, dwr_pkg::IDX_CNT1, 16'h0001);
    nb1 = 0;
    bus(1'b1, dwr_pkg::IDX_CTRL, 16'h0008);
    ticks(30);
    chk("alt ch0 req", 16'h1, {15'h0, CH0_REQ_O});
    chk("alt ch1 idle", 16'h0, 16'(nb1));
    bus(1'b1, dwr_pkg::IDX_CH1_EXT, 16'h00C0);
    ticks(2);
    chk("alt ch0 hid", 16'h0, {15'h0, CH0_REQ_O});
    ticks(30);
    chk("alt ch1 run", 16'h1, 16'(nb1));
    bus(1'b0, dwr_pkg::IDX_CH1_EXT, 16'h0);
    chk("alt cleared", 16'h0080, rv);
    CH0_REQ_N_I <= 1'b1;
    xfer0(1'b1, 16'h0002);
    bus(1'b0, dwr_pkg::IDX_CH1_EXT, 16'h0);
    chk("alt set", 16'h00C0, rv);
    $display("test alternation done");
    results();
  end
endmodule
`default_nettype wire
